// ==== core/cfws_core.v ====
// cfws_core.v - pointer, working register, flags, data ram, watchdog and sleep control
// assumes: the instruction decoder drives one data access or alu op per cycle, on clk
`timescale 1ns/1ps
`default_nettype none
`include "cfws_map.vh"

// Functional notes
// - accesses to address 00H go to the location held in the memory pointer
// - indirect through pointer value 00H reads 00H and writes nothing
// - working register also sits at 05H; memory-to-memory moves pass through it
// - bit 0 carry: add carry out, subtract no borrow, rotate through carry
// - bit 1 half carry: low nibble carry, or no nibble borrow
// - bit 2 zero: set on zero arithmetic or logic result, else cleared
// - bit 3 signed wrap: carry into msb differs from carry out
// - bit 4 sleep flag: cleared at power-up and kick, set by sleep
// - bit 5 expired flag: cleared power-up, kick or sleep; set on timeout
// - flag bits 6 and 7 read as zero
// - plain flag writes change arithmetic flags only, never sleep or expired
// - a call saves only the program counter, flags are not stored
// - watchdog counts instruction clock, system clock divided by four
// - watchdog timeout is 2^n instruction clocks, n from 8 to 11
// - watchdog disabled: its instructions do nothing and no timeout happens
// - watchdog overflow in normal running resets the chip and sets expired
// - cleared by one kick, or only after both two-step kicks, by option
// - sleep stops clock and watchdog, clears prescaler, keeps state, sets sleep flag, clears expired
// - falling edge on a wake-enabled port pin ends sleep; others do not
// - port wake-up continues after the sleep instruction, no reset
// - wake-up waits 1024 system clocks before execution resumes
module cfws_core #(
    parameter WAKE_CYCLES = (`CFWS_WAKE_DELAY_TSYS)
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire       opt_wdt_enable,
    input  wire [1:0] opt_wdt_exp,
    input  wire       opt_two_kick,
    input  wire [7:0] opt_wake_en,
    input  wire [6:0] mem_addr,
    input  wire       mem_rd,
    input  wire       mem_wr,
    input  wire [7:0] mem_wdata,
    output reg  [7:0] mem_rdata,
    output wire [6:0] ext_addr,
    output wire       ext_rd,
    output wire       ext_wr,
    output wire [7:0] ext_wdata,
    input  wire [7:0] ext_rdata,
    input  wire       acc_load,
    input  wire [7:0] acc_din,
    output reg  [7:0] working_register,
    input  wire       alu_go,
    input  wire [2:0] alu_op,
    input  wire [7:0] alu_a,
    input  wire [7:0] alu_b,
    output reg  [7:0] alu_result,
    output wire [7:0] flag_register,
    input  wire       single_watchdog_kick,
    input  wire       first_watchdog_kick,
    input  wire       second_watchdog_kick,
    input  wire       sleep_op,
    input  wire [7:0] wake_port,
    output wire       core_stall,
    output reg        asleep,
    output wire       resume,
    output reg        chip_reset
);

    // data select codes
    localparam [2:0] SEL_NONE    = 3'h0;
    localparam [2:0] SEL_POINTER = 3'h1;
    localparam [2:0] SEL_WORKING = 3'h2;
    localparam [2:0] SEL_FLAGS   = 3'h3;
    localparam [2:0] SEL_RAM     = 3'h4;
    localparam [2:0] SEL_EXT     = 3'h5;

    reg  [7:0] ram [0:31];
    reg  [6:0] memory_pointer;
    reg  [3:0] arith_flags;
    reg        sleep_entered_flag;
    reg        watchdog_expired_flag;
    reg        opt_loaded;
    reg        cfg_wdt_enable;
    reg  [1:0] cfg_wdt_exp;
    reg        cfg_two_kick;
    reg  [7:0] cfg_wake_en;
    reg  [7:0] next_result;
    reg  [3:0] next_arith;
    reg  [8:0] sum9;
    reg  [4:0] sum5;
    reg  [7:0] addend;
    reg        carry_in;
    reg        carry7;
    reg  [7:0] rd_mux;
    wire [6:0] eff_addr;
    wire       indirect;
    wire       null_ptr;
    wire [2:0] sel;
    wire       wdt_timeout;
    wire       kick_done;
    wire       waking;
    wire       do_wr;

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    function [2:0] cfws_decode;
        input [6:0] a;
        begin
            if (a == `CFWS_ADDR_POINTER) begin
                cfws_decode = SEL_POINTER;
            end else if (a == `CFWS_ADDR_WORKING) begin
                cfws_decode = SEL_WORKING;
            end else if (a == `CFWS_ADDR_FLAGS) begin
                cfws_decode = SEL_FLAGS;
            end else if (a >= `CFWS_RAM_BASE && a <= `CFWS_RAM_LAST) begin
                cfws_decode = SEL_RAM;
            end else if (a == `CFWS_ADDR_INDIRECT) begin
                cfws_decode = SEL_NONE;
            end else begin
                cfws_decode = SEL_EXT;
            end
        end
    endfunction

    // address 00H is redirected through the pointer
    assign indirect  = (mem_addr == `CFWS_ADDR_INDIRECT);
    assign eff_addr  = indirect ? memory_pointer : mem_addr;
    assign null_ptr  = indirect && (memory_pointer == `CFWS_ADDR_INDIRECT);
    assign sel       = null_ptr ? SEL_NONE : cfws_decode(eff_addr);
    assign do_wr     = mem_wr && !core_stall;

    // other special registers live outside this block
    assign ext_addr  = eff_addr;
    assign ext_rd    = mem_rd && !core_stall && (sel == SEL_EXT);
    assign ext_wr    = do_wr && (sel == SEL_EXT);
    assign ext_wdata = mem_wdata;

    // unused upper bits read as zero
    assign flag_register = {2'b00, watchdog_expired_flag, sleep_entered_flag,
                            arith_flags};
    assign core_stall    = asleep | waking;

    // -------------------------------------------------------------------
    // build options, captured once after reset release
    // -------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_loaded     <= 1'b0;
            cfg_wdt_enable <= 1'b0;
            cfg_wdt_exp    <= 2'h0;
            cfg_two_kick   <= 1'b0;
            cfg_wake_en    <= 8'h00;
        end else if (clk_en && !opt_loaded) begin
            opt_loaded     <= 1'b1;
            cfg_wdt_enable <= opt_wdt_enable;
            cfg_wdt_exp    <= opt_wdt_exp;
            cfg_two_kick   <= opt_two_kick;
            cfg_wake_en    <= opt_wake_en;
        end
    end

    // -------------------------------------------------------------------
    // alu flag computation
    // -------------------------------------------------------------------
    always @* begin
        addend      = alu_b;
        carry_in    = 1'b0;
        sum9        = 9'h000;
        sum5        = 5'h00;
        carry7      = 1'b0;
        next_result = alu_b;
        next_arith  = arith_flags;
        case (alu_op)
            `CFWS_OP_ADD, `CFWS_OP_ADC, `CFWS_OP_SUB, `CFWS_OP_SBC: begin
                // subtraction is a plus not-b plus one (sub) or plus carry (sbc), carry means no borrow
                if (alu_op == `CFWS_OP_SUB || alu_op == `CFWS_OP_SBC) begin
                    addend = ~alu_b;
                end
                if (alu_op == `CFWS_OP_SUB) begin
                    carry_in = 1'b1;
                end else if (alu_op == `CFWS_OP_ADD) begin
                    carry_in = 1'b0;
                end else begin
                    carry_in = arith_flags[`CFWS_FLAG_CARRY];
                end
                sum9   = {1'b0, alu_a} + {1'b0, addend} + {8'h00, carry_in};
                sum5   = {1'b0, alu_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
                carry7 = alu_a[7] ^ addend[7] ^ sum9[7];
                next_result = sum9[7:0];
                next_arith[`CFWS_FLAG_CARRY] = sum9[8];
                next_arith[`CFWS_FLAG_HALF]  = sum5[4];
                next_arith[`CFWS_FLAG_WRAP]  = carry7 ^ sum9[8];
                next_arith[`CFWS_FLAG_ZERO]  = (sum9[7:0] == 8'h00);
            end
            `CFWS_OP_RLC: begin
                next_result = {alu_a[6:0], arith_flags[`CFWS_FLAG_CARRY]};
                next_arith[`CFWS_FLAG_CARRY] = alu_a[7];
            end
            `CFWS_OP_RRC: begin
                next_result = {arith_flags[`CFWS_FLAG_CARRY], alu_a[7:1]};
                next_arith[`CFWS_FLAG_CARRY] = alu_a[0];
            end
            default: begin
                // logic results come in finished on alu_b
                next_arith[`CFWS_FLAG_ZERO] = (alu_b == 8'h00);
            end
        endcase
    end

    // -------------------------------------------------------------------
    // pointer, working register and arithmetic flags
    // -------------------------------------------------------------------
    // flags are plain state here: control transfers never save or restore them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_pointer   <= `CFWS_POINTER_RESET;
            working_register <= `CFWS_WORKING_RESET;
            arith_flags      <= `CFWS_ARITH_RESET;
            alu_result       <= 8'h00;
        end else if (clk_en) begin
            if (do_wr && sel == SEL_POINTER) begin
                memory_pointer <= mem_wdata[6:0];
            end
            // decoder loads win over a store to 05H in the same cycle
            if (acc_load && !core_stall) begin
                working_register <= acc_din;
            end else if (do_wr && sel == SEL_WORKING) begin
                working_register <= mem_wdata;
            end
            if (alu_go && !core_stall) begin
                alu_result  <= next_result;
                arith_flags <= next_arith;
            end else if (do_wr && sel == SEL_FLAGS) begin
                arith_flags <= mem_wdata[3:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // general purpose ram, no reset
    // -------------------------------------------------------------------
    always @(posedge clk) begin
        if (clk_en && do_wr && sel == SEL_RAM) begin
            ram[eff_addr[4:0]] <= mem_wdata;
        end
    end

    // -------------------------------------------------------------------
    // read data, one cycle after the strobe
    // -------------------------------------------------------------------
    always @* begin
        if (sel == SEL_POINTER) begin
            rd_mux = {1'b1, memory_pointer};
        end else if (sel == SEL_WORKING) begin
            rd_mux = working_register;
        end else if (sel == SEL_FLAGS) begin
            rd_mux = flag_register;
        end else if (sel == SEL_RAM) begin
            rd_mux = ram[eff_addr[4:0]];
        end else if (sel == SEL_EXT) begin
            rd_mux = ext_rdata;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rdata <= 8'h00;
        end else if (clk_en && mem_rd && !core_stall) begin
            mem_rdata <= rd_mux;
        end
    end

    // -------------------------------------------------------------------
    // sleep state, sleep and expired flags, chip reset
    // -------------------------------------------------------------------
    // set wins over clear when both land in one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            asleep                <= 1'b0;
            sleep_entered_flag    <= 1'b0;
            watchdog_expired_flag <= 1'b0;
            chip_reset            <= 1'b0;
        end else if (clk_en) begin
            chip_reset <= wdt_timeout && !asleep;
            if (sleep_op && !core_stall) begin
                asleep             <= 1'b1;
                sleep_entered_flag <= 1'b1;
            end else if (kick_done) begin
                sleep_entered_flag <= 1'b0;
            end
            if (resume) begin
                asleep <= 1'b0;
            end
            if (wdt_timeout) begin
                watchdog_expired_flag <= 1'b1;
            end else if (kick_done || (sleep_op && !core_stall)) begin
                watchdog_expired_flag <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // watchdog and wake-up
    // -------------------------------------------------------------------
    cfws_watchdog #(
        .CNT_W (12)
    ) u_watchdog (
        .clk         (clk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .enable      (cfg_wdt_enable & opt_loaded),
        .run         (!core_stall),
        .exp_sel     (cfg_wdt_exp),
        .two_kick    (cfg_two_kick),
        .kick_single (single_watchdog_kick & !core_stall),
        .kick_first  (first_watchdog_kick & !core_stall),
        .kick_second (second_watchdog_kick & !core_stall),
        .sleep_clear (sleep_op & !core_stall),
        .timeout     (wdt_timeout),
        .kick_done   (kick_done)
    );

    cfws_wake #(
        .WAKE_CYCLES (WAKE_CYCLES)
    ) u_wake (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .wake_port (wake_port),
        .wake_en   (cfg_wake_en),
        .asleep    (asleep),
        .waking    (waking),
        .resume    (resume)
    );

endmodule
`default_nettype wire

// ==== core/cfws_map.vh ====
// cfws_map.vh - data address map, flag bit positions, reset values and timing counts
// assumes: included by the cfws core files only, never compiled on its own
`ifndef CFWS_MAP_VH
`define CFWS_MAP_VH

// -------------------------------------------------------------------
// data memory map
// -------------------------------------------------------------------
`define CFWS_ADDR_INDIRECT   7'h00
`define CFWS_ADDR_POINTER    7'h01
`define CFWS_ADDR_WORKING    7'h05
`define CFWS_ADDR_FLAGS      7'h0A
`define CFWS_RAM_BASE        7'h20
`define CFWS_RAM_LAST        7'h3F

// -------------------------------------------------------------------
// flag register layout
// -------------------------------------------------------------------
`define CFWS_FLAG_CARRY      0
`define CFWS_FLAG_HALF       1
`define CFWS_FLAG_ZERO       2
`define CFWS_FLAG_WRAP       3
`define CFWS_FLAG_SLEEP      4
`define CFWS_FLAG_EXPIRED    5
`define CFWS_ARITH_MASK      8'h0F

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define CFWS_POINTER_RESET   7'h00
`define CFWS_WORKING_RESET   8'h00
`define CFWS_ARITH_RESET     4'h0

// -------------------------------------------------------------------
// alu operation codes
// -------------------------------------------------------------------
`define CFWS_OP_ADD          3'h0
`define CFWS_OP_ADC          3'h1
`define CFWS_OP_SUB          3'h2
`define CFWS_OP_SBC          3'h3
`define CFWS_OP_LOGIC        3'h4
`define CFWS_OP_RLC          3'h5
`define CFWS_OP_RRC          3'h6

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define CFWS_CLK_NS          50
`define CFWS_WDT_DIV         4
`define CFWS_WDT_EXP_MIN     8
`define CFWS_WAKE_DELAY_TSYS 1024

`endif

// ==== core/cfws_watchdog.v ====
// cfws_watchdog.v - watchdog with divide-by-four instruction clock and 2^n timeout
// assumes: kicks and sleep are one-cycle pulses from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "cfws_map.vh"

module cfws_watchdog #(
    parameter CNT_W = 12
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire       enable,
    input  wire       run,
    input  wire [1:0] exp_sel,
    input  wire       two_kick,
    input  wire       kick_single,
    input  wire       kick_first,
    input  wire       kick_second,
    input  wire       sleep_clear,
    output reg        timeout,
    output wire       kick_done
);

    reg  [1:0]       prescale;
    reg  [CNT_W-1:0] count;
    reg              seen_first;
    reg              seen_second;
    wire             tick;
    wire             both_seen;
    wire [CNT_W-1:0] limit;

    // two-kick mode needs both kinds, in either order
    assign both_seen = (seen_first | kick_first) & (seen_second | kick_second);
    assign kick_done = enable & (two_kick ? both_seen : kick_single);
    // instruction clock tick every fourth system clock
    assign tick      = run & (prescale == 2'h3);
    // last count of a 2^n period, n = 8 + exp_sel
    assign limit     = (({{(CNT_W-1){1'b0}}, 1'b1}) << (`CFWS_WDT_EXP_MIN + exp_sel)) -
                       {{(CNT_W-1){1'b0}}, 1'b1};

    // -------------------------------------------------------------------
    // prescaler, divider and kick tracking
    // -------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale    <= 2'h0;
            count       <= {CNT_W{1'b0}};
            seen_first  <= 1'b0;
            seen_second <= 1'b0;
            timeout     <= 1'b0;
        end else if (clk_en) begin
            timeout <= 1'b0;
            if (!enable) begin
                prescale <= 2'h0;
                count    <= {CNT_W{1'b0}};
            end else if (sleep_clear || kick_done) begin
                prescale    <= 2'h0;
                count       <= {CNT_W{1'b0}};
                seen_first  <= 1'b0;
                seen_second <= 1'b0;
            end else begin
                if (kick_first && two_kick) begin
                    seen_first <= 1'b1;
                end
                if (kick_second && two_kick) begin
                    seen_second <= 1'b1;
                end
                if (run) begin
                    prescale <= prescale + 2'h1;
                end
                if (tick) begin
                    if (count == limit) begin
                        count   <= {CNT_W{1'b0}};
                        timeout <= 1'b1;
                    end else begin
                        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== core/cfws_wake.v ====
// cfws_wake.v - wake-port falling edge detect and resume delay
// assumes: wake_port pins are asynchronous; asleep comes from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "cfws_map.vh"

module cfws_wake #(
    parameter WAKE_CYCLES = (`CFWS_WAKE_DELAY_TSYS)
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire [7:0] wake_port,
    input  wire [7:0] wake_en,
    input  wire       asleep,
    output reg        waking,
    output reg        resume
);

    localparam [10:0] LAST = WAKE_CYCLES[10:0] - 11'h1;

    reg  [7:0]  sync_a;
    reg  [7:0]  sync_b;
    reg  [7:0]  sync_c;
    reg  [10:0] delay;
    wire        wake_edge;

    // falling edge only on pins selected to wake
    assign wake_edge = |(sync_c & ~sync_b & wake_en);

    // -------------------------------------------------------------------
    // synchroniser and resume delay
    // -------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 8'hFF;
            sync_b <= 8'hFF;
            sync_c <= 8'hFF;
            delay  <= 11'h000;
            waking <= 1'b0;
            resume <= 1'b0;
        end else if (clk_en) begin
            sync_a <= wake_port;
            sync_b <= sync_a;
            sync_c <= sync_b;
            resume <= 1'b0;
            if (waking) begin
                if (delay == LAST) begin
                    waking <= 1'b0;
                    resume <= 1'b1;
                end else begin
                    delay <= delay + 11'h001;
                end
            end else if (asleep && wake_edge) begin
                waking <= 1'b1;
                delay  <= 11'h000;
            end
        end
    end

endmodule
`default_nettype wire

// ==== tb/cfws_ext_mem.sv ====
// partner: plain data space behind the external forward port
// assumes: read data is taken in the cycle of the access
`timescale 1ns/1ps
`default_nettype none
module cfws_ext_mem (
    input  wire logic       clk,
    input  wire logic [6:0] ext_addr,
    input  wire logic       ext_rd,
    input  wire logic       ext_wr,
    input  wire logic [7:0] ext_wdata,
    output var  logic [7:0] ext_rdata
);
    logic [7:0] mem [0:127];
    logic [7:0] last = 8'h00;
    // idle bus shows the inverse of the last read
    always_comb ext_rdata = ext_rd ? mem[ext_addr] : ~last;
    always @(posedge clk) begin
        if (ext_wr) mem[ext_addr] <= ext_wdata;
        if (ext_rd) last <= mem[ext_addr];
    end
endmodule
`default_nettype wire

// ==== tb/cfws_core_properties.sv ====
// checker: timing relations at the cfws_core ports
// assumes: bound into every cfws_core instance
`timescale 1ns/1ps
`default_nettype none
module cfws_core_properties #(parameter WAKE_CYCLES = 1024) (
    input wire logic clk, rst_n, clk_en, opt_wdt_enable, opt_two_kick,
    input wire logic [7:0] opt_wake_en, wake_port, mem_rdata, alu_b, flag_register,
    input wire logic [6:0] mem_addr,
    input wire logic [2:0] alu_op,
    input wire logic mem_rd, mem_wr, alu_go, single_watchdog_kick, sleep_op,
    input wire logic core_stall, asleep, resume, chip_reset
);
    localparam int LO = WAKE_CYCLES;
    localparam int HI = WAKE_CYCLES + 8;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a request is taken only while running
    wire logic go = clk_en && !core_stall;
    sequence s_sleep_take; go && sleep_op; endsequence
    sequence s_pin_fall; asleep && opt_wake_en[0] && $fell(wake_port[0]); endsequence
    a_top_bits_zero: assert property (flag_register[7:6] == 2'b00)
        else $error("flag top bits set");
    a_sleep_flags: assert property (s_sleep_take |=> asleep && flag_register[5:4] == 2'b01)
        else $error("sleep flags wrong");
    a_pointer_msb: assert property (go && mem_rd && mem_addr == 7'h01 |=> mem_rdata[7])
        else $error("pointer msb low");
    a_flag_write_keep: assert property (go && mem_wr && mem_addr == 7'h0A && !sleep_op
        && !single_watchdog_kick |=> $stable(flag_register[5:4]))
        else $error("flag write hit state bits");
    a_logic_zero: assert property (go && alu_go && alu_op == 3'h4
        |=> flag_register[2] == ($past(alu_b) == 8'h00))
        else $error("zero flag wrong");
    a_kick_clears: assert property (go && single_watchdog_kick && opt_wdt_enable && !opt_two_kick
        && !sleep_op |=> chip_reset || flag_register[5:4] == 2'b00)
        else $error("kick left flags");
    a_reset_pulse: assert property (chip_reset |=> !chip_reset && flag_register[5])
        else $error("timeout pulse wrong");
    a_pin_wake: assert property (s_pin_fall |-> ##[LO:HI] resume)
        else $error("wake delay wrong");
    a_resume_run: assert property (resume |-> ##[0:1] !core_stall)
        else $error("stall after resume");
    a_off_no_reset: assert property (!opt_wdt_enable |-> !chip_reset)
        else $error("timeout while disabled");
endmodule
bind cfws_core cfws_core_properties #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: cfws_core with an external data model
// assumes: the checker binds itself into cfws_core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, wen = 0, two = 0, rd = 0, wr = 0, ld = 0, go = 0, sl = 0;
    logic [2:0] op = 0, kk = 0;
    logic [6:0] ad = 0, ea;
    logic [7:0] wd = 0, a = 0, b = 0, pins = 8'hFF, dn = 0, rdat, er, ew, acc, res, fl;
    logic erd, ewr, stall, slp, rsm, crst;
    int err_count = 0, check_count = 0, c;
    cfws_core #(.WAKE_CYCLES(8)) dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .opt_wdt_enable(wen), .opt_wdt_exp(2'b00), .opt_two_kick(two), .opt_wake_en(8'h01),
        .mem_addr(ad), .mem_rd(rd), .mem_wr(wr), .mem_wdata(wd), .mem_rdata(rdat),
        .ext_addr(ea), .ext_rd(erd), .ext_wr(ewr), .ext_wdata(ew), .ext_rdata(er),
        .acc_load(ld), .acc_din(dn), .working_register(acc), .alu_go(go), .alu_op(op),
        .alu_a(a), .alu_b(b), .alu_result(res), .flag_register(fl),
        .single_watchdog_kick(kk[2]), .first_watchdog_kick(kk[1]),
        .second_watchdog_kick(kk[0]), .sleep_op(sl), .wake_port(pins),
        .core_stall(stall), .asleep(slp), .resume(rsm), .chip_reset(crst));
    cfws_ext_mem ext_u (.clk(clk), .ext_addr(ea), .ext_rd(erd), .ext_wr(ewr),
        .ext_wdata(ew), .ext_rdata(er));
    initial forever #25 clk = ~clk;
    // compare, count, report
    task chk(string n, logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr_b(logic [6:0] x, logic [7:0] d);
        @(posedge clk) {ad, wd, wr} <= {x, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    task rd_b(logic [6:0] x, logic [7:0] e);
        @(posedge clk) {ad, rd} <= {x, 1'b1};
        @(posedge clk) rd <= 0;
        @(negedge clk) chk("mem_rdata", rdat, e);
    endtask
    task alu(logic [2:0] o, logic [7:0] x, y, r, f);
        @(posedge clk) {op, a, b, go} <= {o, x, y, 1'b1};
        @(posedge clk) go <= 0;
        @(negedge clk) chk("alu_result", res, r);
        chk("flag_register", fl, f);
    endtask
    task kick(logic [2:0] k);
        @(posedge clk) kk <= k;
        @(posedge clk) kk <= 0;
    endtask
    // bounded wait on resume (r=1) or chip_reset (r=0), cycles in c
    task wt(int n, bit r);
        c = 0;
        while (c < n && (r ? rsm : crst) !== 1'b1) begin
            @(negedge clk);
            c++;
        end
    endtask
    task boot(logic e, t);
        @(posedge clk) {wen, two, rst_n} <= {e, t, 1'b0};
        repeat (6) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(negedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog off: memory map, flags, sleep and wake
    initial begin
        boot(0, 0);
        rd_b(7'h01, 8'h80);
        wr_b(7'h01, 8'hA3);
        rd_b(7'h01, 8'hA3);
        wr_b(7'h00, 8'h5C);
        rd_b(7'h23, 8'h5C);
        rd_b(7'h00, 8'h5C);
        wr_b(7'h01, 8'h00);
        wr_b(7'h00, 8'h77);
        rd_b(7'h00, 8'h00);
        rd_b(7'h01, 8'h80);
        wr_b(7'h50, 8'h96);
        rd_b(7'h50, 8'h96);
        @(posedge clk) {ld, dn} <= {1'b1, 8'h3C};
        @(posedge clk) ld <= 0;
        rd_b(7'h05, 8'h3C);
        wr_b(7'h05, 8'h4B);
        @(negedge clk) chk("working_register", acc, 8'h4B);
        wr_b(7'h0A, 8'hFF);
        rd_b(7'h0A, 8'h0F);
        alu(3'h0, 8'h80, 8'h80, 8'h00, 8'h0D);
        alu(3'h0, 8'h0F, 8'h01, 8'h10, 8'h02);
        alu(3'h2, 8'h05, 8'h03, 8'h02, 8'h03);
        alu(3'h4, 8'h00, 8'h00, 8'h00, 8'h07);
        alu(3'h5, 8'h81, 8'h00, 8'h03, 8'h07);
        alu(3'h1, 8'h7F, 8'h00, 8'h80, 8'h0A);
        wt(1100, 0);
        chk("no_timeout", c == 1100, 1);
        @(posedge clk) sl <= 1;
        @(posedge clk) sl <= 0;
        @(negedge clk) chk("flag_register", fl, 8'h1A);
        wr_b(7'h05, 8'hFF);
        @(negedge clk) chk("working_register", acc, 8'h4B);
        @(posedge clk) pins <= 8'hFD;
        repeat (30) @(negedge clk);
        chk("asleep", slp, 1);
        @(posedge clk) pins <= 8'hFC;
        wt(40, 1);
        chk("wake_delay", c >= 8 && c <= 16, 1);
        wr_b(7'h05, 8'h5A);
        @(negedge clk) chk("working_register", acc, 8'h5A);
        kick(3'b100);
        @(negedge clk) chk("flag_register", fl, 8'h1A);
        // watchdog on, single kick mode
        boot(1, 0);
        chk("flag_register", fl, 8'h00);
        wt(1200, 0);
        chk("timeout_cycles", c >= 1015 && c <= 1035, 1);
        @(negedge clk) chk("flag_register", fl & 8'h20, 8'h20);
        kick(3'b100);
        @(negedge clk) chk("flag_register", fl & 8'h30, 8'h00);
        repeat (2) begin
            repeat (700) @(posedge clk);
            kick(3'b100);
        end
        wt(700, 0);
        chk("kept_alive", c == 700, 1);
        // two kick mode: a lone first kick does not clear
        boot(1, 1);
        repeat (500) @(posedge clk);
        kick(3'b010);
        wt(600, 0);
        chk("lone_kick", c < 600, 1);
        kick(3'b010);
        kick(3'b001);
        wt(900, 0);
        chk("pair_kick", c == 900, 1);
        final_report;
    end
endmodule
`default_nettype wire
